// *** common/cbc_pkg.sv ***
// Package for the compare and bit-clear execution unit
package cbc_pkg;
    // Opcodes
    localparam logic [11:0] OP_CLEAR_BIT   = 12'h58c;
    localparam logic [11:0] OP_CMP_ORD     = 12'h5a0;
    localparam logic [11:0] OP_CMP_INT     = 12'h5a1;
    localparam logic [11:0] OP_CMPINC_ORD  = 12'h5a4;
    localparam logic [11:0] OP_CMPINC_INT  = 12'h5a5;
    localparam logic [11:0] OP_CMPDEC_ORD  = 12'h5a6;
    localparam logic [11:0] OP_CMPDEC_INT  = 12'h5a7;
    localparam logic [11:0] OP_CMP_REAL    = 12'h684;
    localparam logic [11:0] OP_CMP_LREAL   = 12'h694;
    // Condition code values
    localparam logic [2:0]  CC_LESS        = 3'h4;
    localparam logic [2:0]  CC_EQUAL       = 3'h2;
    localparam logic [2:0]  CC_GREATER     = 3'h1;
    localparam logic [2:0]  CC_UNORDERED   = 3'h0;
    // Real formats, bit-clear and register pair masks
    localparam int          SGL_EXP_MSB    = 30;
    localparam int          SGL_EXP_LSB    = 23;
    localparam int          DBL_EXP_MSB    = 62;
    localparam int          DBL_EXP_LSB    = 52;
    localparam logic [4:0]  BITPOS_MASK    = 5'h1f;
    localparam logic [4:0]  REG_PAIR_MASK  = 5'h1e;
    // Reset values
    localparam logic [31:0] RST_RESULT     = 32'h0;
    localparam logic [2:0]  RST_CC         = 3'h0;
    // Result latency in cycles
    localparam int          LATENCY        = 1;
endpackage : cbc_pkg

// *** hw/cbc_unit.sv ***
// Compare and bit-clear execution datapath
// Contract
// - Bit clear writes source with one bit zeroed
// - Compares give 100 less, 010 equal, 001 greater
// - Integer compare 5A1, ordinal 5A0, reg/literal operands
// - Compare-decrement sets code, writes second minus one
// - Integer decrement wraps without any overflow fault
// - Compare-increment sets code, writes second plus one
// - Integer increment wraps without any overflow fault
// - Ordered real NaN gives 000, invalid-operation raised
// - Long real register names low even pair
// - Code undefined on reserved-encoding fault
// - Unnormal operand with normalizing mode faults
// - Invalid operation faults only when unmasked
module cbc_unit
    import cbc_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_valid,
    input  wire logic [11:0] i_opcode,
    input  wire logic [4:0]  i_first_reg,
    input  wire logic [4:0]  i_second_reg,
    input  wire logic [63:0] i_first_operand,
    input  wire logic [63:0] i_second_operand,
    input  wire logic        i_norm_mode,
    input  wire logic        i_invalid_mask,
    output logic             o_done,
    output logic [31:0]      o_result,
    output logic             o_result_we,
    output logic             o_cc_we,
    output logic [2:0]       o_condition_code_field,
    output logic             o_invalid_raised,
    output logic             o_invalid_fault,
    output logic             o_reserved_fault,
    output logic [4:0]       o_first_pair_reg,
    output logic [4:0]       o_second_pair_reg,
    output logic             o_unknown_op
);
    typedef enum logic [1:0] {CBC_OP_BIT, CBC_OP_INT, CBC_OP_REAL, CBC_OP_NONE} cbc_class_e;

    cbc_class_e  op_class;
    logic        signed_cmp;
    logic        is_dec;
    logic        is_inc;
    logic        is_long;
    logic [31:0] a32;
    logic [31:0] b32;
    logic [31:0] clear_mask;
    logic        a_nan;
    logic        b_nan;
    logic        a_unnorm;
    logic        b_unnorm;
    logic        r_less;
    logic        r_equal;
    logic [2:0]  int_cc;
    logic [2:0]  real_cc;

    logic        next_done;
    logic [31:0] next_result;
    logic        next_result_we;
    logic        next_cc_we;
    logic [2:0]  next_cc;
    logic        next_inv;
    logic        next_inv_fault;
    logic        next_res_fault;
    logic [4:0]  next_first_pair;
    logic [4:0]  next_second_pair;
    logic        next_unknown;

    assign a32 = i_first_operand[31:0];
    assign b32 = i_second_operand[31:0];

    // Clear mask built one bit per position; bit index is low five bits only
    for (genvar g = 0; g < 32; g++) begin : g_mask
        assign clear_mask[g] = ((i_opcode == OP_CLEAR_BIT) && ((a32[4:0] & BITPOS_MASK) == 5'(g)));
    end

    // Real classification; denormal exponent field is all zero with fraction set
    always_comb begin
        is_long = (i_opcode == OP_CMP_LREAL);
        if (is_long) begin
            a_nan    = (&i_first_operand[DBL_EXP_MSB:DBL_EXP_LSB]) && (|i_first_operand[DBL_EXP_LSB-1:0]);
            b_nan    = (&i_second_operand[DBL_EXP_MSB:DBL_EXP_LSB]) && (|i_second_operand[DBL_EXP_LSB-1:0]);
            a_unnorm = (~|i_first_operand[DBL_EXP_MSB:DBL_EXP_LSB]) && (|i_first_operand[DBL_EXP_LSB-1:0]);
            b_unnorm = (~|i_second_operand[DBL_EXP_MSB:DBL_EXP_LSB]) && (|i_second_operand[DBL_EXP_LSB-1:0]);
        end else begin
            a_nan    = (&a32[SGL_EXP_MSB:SGL_EXP_LSB]) && (|a32[SGL_EXP_LSB-1:0]);
            b_nan    = (&b32[SGL_EXP_MSB:SGL_EXP_LSB]) && (|b32[SGL_EXP_LSB-1:0]);
            a_unnorm = (~|a32[SGL_EXP_MSB:SGL_EXP_LSB]) && (|a32[SGL_EXP_LSB-1:0]);
            b_unnorm = (~|b32[SGL_EXP_MSB:SGL_EXP_LSB]) && (|b32[SGL_EXP_LSB-1:0]);
        end
    end

    // Sign-magnitude real compare; plus and minus zero are equal
    function automatic logic [1:0] real_cmp(input logic [63:0] a, input logic [63:0] b, input logic lng);
        logic [63:0] ma;
        logic [63:0] mb;
        logic        sa;
        logic        sb;
        logic        lt;
        logic        eq;
        ma = lng ? {1'b0, a[62:0]} : {33'h0, a[30:0]};
        mb = lng ? {1'b0, b[62:0]} : {33'h0, b[30:0]};
        sa = lng ? a[63] : a[31];
        sb = lng ? b[63] : b[31];
        eq = ((ma == 64'h0) && (mb == 64'h0)) || ((sa == sb) && (ma == mb));
        if (eq)
            lt = 1'b0;
        else if (sa != sb)
            lt = sa;
        else
            lt = sa ? (ma > mb) : (ma < mb);
        real_cmp = {lt, eq};
    endfunction

    // Opcode decode
    always_comb begin
        op_class   = CBC_OP_NONE;
        signed_cmp = 1'b0;
        is_dec     = 1'b0;
        is_inc     = 1'b0;
        case (i_opcode)
            OP_CLEAR_BIT:  op_class = CBC_OP_BIT;
            OP_CMP_INT: begin
                op_class   = CBC_OP_INT;
                signed_cmp = 1'b1;
            end
            OP_CMP_ORD:    op_class = CBC_OP_INT;
            OP_CMPDEC_INT: begin
                op_class   = CBC_OP_INT;
                signed_cmp = 1'b1;
                is_dec     = 1'b1;
            end
            OP_CMPDEC_ORD: begin
                op_class = CBC_OP_INT;
                is_dec   = 1'b1;
            end
            OP_CMPINC_INT: begin
                op_class   = CBC_OP_INT;
                signed_cmp = 1'b1;
                is_inc     = 1'b1;
            end
            OP_CMPINC_ORD: begin
                op_class = CBC_OP_INT;
                is_inc   = 1'b1;
            end
            OP_CMP_REAL, OP_CMP_LREAL: op_class = CBC_OP_REAL;
            default:       op_class = CBC_OP_NONE;
        endcase
    end

    // Integer and ordinal condition code
    always_comb begin
        if (signed_cmp ? ($signed(a32) < $signed(b32)) : (a32 < b32))
            int_cc = CC_LESS;
        else if (a32 == b32)
            int_cc = CC_EQUAL;
        else
            int_cc = CC_GREATER;
    end

    // Real condition code; NaN check comes first so it overrides any ordering
    always_comb begin
        {r_less, r_equal} = real_cmp(i_first_operand, i_second_operand, is_long);
        if (a_nan || b_nan)
            real_cc = CC_UNORDERED;
        else if (r_less)
            real_cc = CC_LESS;
        else if (r_equal)
            real_cc = CC_EQUAL;
        else
            real_cc = CC_GREATER;
    end

    // Next values for one issued operation
    always_comb begin
        next_done        = i_valid;
        next_result      = RST_RESULT;
        next_result_we   = 1'b0;
        next_cc_we       = 1'b0;
        next_cc          = o_condition_code_field;
        next_inv         = 1'b0;
        next_inv_fault   = 1'b0;
        next_res_fault   = 1'b0;
        next_first_pair  = i_first_reg;
        next_second_pair = i_second_reg;
        next_unknown     = 1'b0;
        if (i_valid) begin
            case (op_class)
                CBC_OP_BIT: begin
                    next_result    = b32 & ~clear_mask;
                    next_result_we = 1'b1;
                end
                CBC_OP_INT: begin
                    next_cc_we = 1'b1;
                    next_cc    = int_cc;
                    // Plain 32-bit wrap; no overflow signal exists on purpose
                    if (is_dec) begin
                        next_result    = b32 - 32'h1;
                        next_result_we = 1'b1;
                    end else if (is_inc) begin
                        next_result    = b32 + 32'h1;
                        next_result_we = 1'b1;
                    end
                end
                CBC_OP_REAL: begin
                    if (is_long) begin
                        // Pair base is the even register; odd names are a software error
                        next_first_pair  = i_first_reg & REG_PAIR_MASK;
                        next_second_pair = i_second_reg & REG_PAIR_MASK;
                    end
                    // Reserved encoding wins; code is left unchanged then
                    if (i_norm_mode && (a_unnorm || b_unnorm)) begin
                        next_res_fault = 1'b1;
                    end else begin
                        next_cc_we     = 1'b1;
                        next_cc        = real_cc;
                        next_inv       = a_nan || b_nan;
                        next_inv_fault = (a_nan || b_nan) && !i_invalid_mask;
                    end
                end
                default: next_unknown = 1'b1;
            endcase
        end
    end

    // Registered outputs
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_done                 <= 1'b0;
            o_result               <= RST_RESULT;
            o_result_we            <= 1'b0;
            o_cc_we                <= 1'b0;
            o_condition_code_field <= RST_CC;
            o_invalid_raised       <= 1'b0;
            o_invalid_fault        <= 1'b0;
            o_reserved_fault       <= 1'b0;
            o_first_pair_reg       <= 5'h0;
            o_second_pair_reg      <= 5'h0;
            o_unknown_op           <= 1'b0;
        end else begin
            o_done                 <= next_done;
            o_result               <= next_result;
            o_result_we            <= next_result_we;
            o_cc_we                <= next_cc_we;
            o_condition_code_field <= next_cc;
            o_invalid_raised       <= next_inv;
            o_invalid_fault        <= next_inv_fault;
            o_reserved_fault       <= next_res_fault;
            o_first_pair_reg       <= next_first_pair;
            o_second_pair_reg      <= next_second_pair;
            o_unknown_op           <= next_unknown;
        end
    end

    // Checks
    property p_clrbit;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_valid && i_opcode == OP_CLEAR_BIT) |=>
            o_result_we && o_result == ($past(b32) & ~(32'h1 << $past(a32[4:0])));
    endproperty
    a_clrbit: assert property (p_clrbit) else $error("bit clear result wrong");

    property p_cmp_code;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_valid && i_opcode == OP_CMP_ORD && a32 < b32) |=> o_cc_we && o_condition_code_field == CC_LESS;
    endproperty
    a_cmp_code: assert property (p_cmp_code) else $error("ordinal less code wrong");

    property p_signed;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_valid && i_opcode == OP_CMP_INT && a32[31] && !b32[31]) |=> o_condition_code_field == CC_LESS;
    endproperty
    a_signed: assert property (p_signed) else $error("signed compare wrong");

    property p_dec;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_valid && (i_opcode == OP_CMPDEC_INT || i_opcode == OP_CMPDEC_ORD)) |=>
            o_result_we && o_result == $past(b32) - 32'h1;
    endproperty
    a_dec: assert property (p_dec) else $error("decrement result wrong");

    property p_dec_wrap;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_valid && i_opcode == OP_CMPDEC_INT && b32 == 32'h80000000) |=>
            o_result == 32'h7fffffff && !o_invalid_fault && !o_reserved_fault;
    endproperty
    a_dec_wrap: assert property (p_dec_wrap) else $error("decrement wrap wrong");

    property p_inc;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_valid && (i_opcode == OP_CMPINC_INT || i_opcode == OP_CMPINC_ORD)) |=>
            o_result_we && o_result == $past(b32) + 32'h1;
    endproperty
    a_inc: assert property (p_inc) else $error("increment result wrong");

    property p_inc_wrap;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_valid && i_opcode == OP_CMPINC_INT && b32 == 32'h7fffffff) |=> o_result == 32'h80000000;
    endproperty
    a_inc_wrap: assert property (p_inc_wrap) else $error("increment wrap wrong");

    property p_nan;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_valid && op_class == CBC_OP_REAL && (a_nan || b_nan) && !i_norm_mode) |=>
            o_condition_code_field == CC_UNORDERED && o_invalid_raised;
    endproperty
    a_nan_code: assert property (p_nan) else $error("NaN compare wrong");

    property p_pair;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_valid && i_opcode == OP_CMP_LREAL) |=> !o_first_pair_reg[0] && !o_second_pair_reg[0] &&
            o_first_pair_reg[4:1] == $past(i_first_reg[4:1]) && o_second_pair_reg[4:1] == $past(i_second_reg[4:1]);
    endproperty
    a_pair: assert property (p_pair) else $error("pair base not even");

    property p_reserved;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_valid && op_class == CBC_OP_REAL && i_norm_mode && (a_unnorm || b_unnorm)) |=>
            o_reserved_fault && !o_cc_we;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved fault missing");

    property p_mask;
        @(posedge i_clk) disable iff (!i_rst_n)
        o_invalid_fault |-> o_invalid_raised && !$past(i_invalid_mask);
    endproperty
    a_mask: assert property (p_mask) else $error("masked invalid faulted");
endmodule // cbc_unit

// *** verification/cbc_unit_tb.sv ***
// Self-checking testbench for the compare and bit-clear execution unit
module cbc_unit_tb
    import cbc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        i_clk;
    logic        i_rst_n;
    logic        i_valid;
    logic [11:0] i_opcode;
    logic [4:0]  i_first_reg;
    logic [4:0]  i_second_reg;
    logic [63:0] i_first_operand;
    logic [63:0] i_second_operand;
    logic        i_norm_mode;
    logic        i_invalid_mask;
    logic        o_done;
    logic [31:0] o_result;
    logic        o_result_we;
    logic        o_cc_we;
    logic [2:0]  o_condition_code_field;
    logic        o_invalid_raised;
    logic        o_invalid_fault;
    logic        o_reserved_fault;
    logic [4:0]  o_first_pair_reg;
    logic [4:0]  o_second_pair_reg;
    logic        o_unknown_op;
    int          fails;
    int          n_compared;
    int          cycles;

    cbc_unit u_cbc_unit (
        .i_clk                  (i_clk),
        .i_rst_n                (i_rst_n),
        .i_valid                (i_valid),
        .i_opcode               (i_opcode),
        .i_first_reg            (i_first_reg),
        .i_second_reg           (i_second_reg),
        .i_first_operand        (i_first_operand),
        .i_second_operand       (i_second_operand),
        .i_norm_mode            (i_norm_mode),
        .i_invalid_mask         (i_invalid_mask),
        .o_done                 (o_done),
        .o_result               (o_result),
        .o_result_we            (o_result_we),
        .o_cc_we                (o_cc_we),
        .o_condition_code_field (o_condition_code_field),
        .o_invalid_raised       (o_invalid_raised),
        .o_invalid_fault        (o_invalid_fault),
        .o_reserved_fault       (o_reserved_fault),
        .o_first_pair_reg       (o_first_pair_reg),
        .o_second_pair_reg      (o_second_pair_reg),
        .o_unknown_op           (o_unknown_op)
    );

    // 100 ns clock
    always #50 i_clk = ~i_clk;

    // Hang guard; whole run needs well under a hundred cycles
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (fails == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One issue; idle edge first so valid is never lowered and raised in one step
    task automatic run(input logic [11:0] op, input logic [63:0] a, input logic [63:0] b);
        @(posedge i_clk);
        #1;
        i_opcode = op;
        i_first_operand = a;
        i_second_operand = b;
        i_valid = 1'b1;
        @(posedge i_clk);
        #1;
        i_valid = 1'b0;
        check("done", o_done, 1'b1);
    endtask

    // Compare with a write-back, result and code both checked
    task automatic run_wb(input logic [11:0] op, input logic [31:0] a, input logic [31:0] b,
                          input logic [2:0] cc, input logic [31:0] res);
        run(op, {32'h0, a}, {32'h0, b});
        check("cc", o_condition_code_field, cc);
        check("result", o_result, res);
        check("result_we", o_result_we, 1'b1);
        check("invalid", o_invalid_raised, 1'b0);
    endtask

    task automatic t_clear_bit();
        run(OP_CLEAR_BIT, 64'h23, 64'hffffffff);
        check("clr result", o_result, 32'hfffffff7);
        check("clr we", o_result_we, 1'b1);
        run(OP_CLEAR_BIT, 64'h1f, 64'h80000001);
        check("clr msb", o_result, 32'h00000001);
    endtask

    task automatic t_compare();
        run(OP_CMP_INT, 64'hffffffff, 64'h1);
        check("cmpi lt", o_condition_code_field, 3'h4);
        check("cmpi cc_we", o_cc_we, 1'b1);
        check("cmpi no wb", o_result_we, 1'b0);
        run(OP_CMP_ORD, 64'hffffffff, 64'h1);
        check("cmpo gt", o_condition_code_field, 3'h1);
        run(OP_CMP_INT, 64'h5, 64'h5);
        check("cmpi eq", o_condition_code_field, 3'h2);
    endtask

    task automatic t_dec_inc();
        run_wb(OP_CMPDEC_INT, 32'd12, 32'd7, 3'h1, 32'd6);
        run_wb(OP_CMPDEC_INT, 32'h0, 32'h80000000, 3'h1, 32'h7fffffff);
        run_wb(OP_CMPDEC_ORD, 32'h0, 32'h80000000, 3'h4, 32'h7fffffff);
        run_wb(OP_CMPINC_INT, 32'h0, 32'h7fffffff, 3'h4, 32'h80000000);
        run_wb(OP_CMPINC_ORD, 32'h1, 32'hffffffff, 3'h4, 32'h0);
        run_wb(OP_CMPINC_INT, 32'h1, 32'hffffffff, 3'h1, 32'h0);
    endtask

    // Ordered real: NaN with both mask settings, ordinary values, long pairs
    task automatic t_real();
        for (int m = 0; m < 2; m++) begin
            i_invalid_mask = m[0];
            run(OP_CMP_REAL, 64'h7fc00000, 64'h3f800000);
            check("nan cc", o_condition_code_field, 3'h0);
            check("nan raised", o_invalid_raised, 1'b1);
            check("nan fault", o_invalid_fault, !m[0]);
        end
        run(OP_CMP_REAL, 64'hbf800000, 64'h3f800000);
        check("real lt", o_condition_code_field, 3'h4);
        check("real no inv", o_invalid_raised, 1'b0);
        // Software names only even registers for long operands
        i_first_reg = 5'd6;
        i_second_reg = 5'd12;
        run(OP_CMP_LREAL, 64'h4000000000000000, 64'h3ff0000000000000);
        check("lreal gt", o_condition_code_field, 3'h1);
        check("pair one", o_first_pair_reg, 5'd6);
        check("pair two", o_second_pair_reg, 5'd12);
        run(OP_CMP_LREAL, 64'h3ff0000000000000, 64'h7ff0000000000001);
        check("lnan cc", o_condition_code_field, 3'h0);
        check("lnan raised", o_invalid_raised, 1'b1);
    endtask

    // Denormal operand faults only in normalizing mode; code then not judged
    task automatic t_reserved();
        i_norm_mode = 1'b1;
        run(OP_CMP_REAL, 64'h00000001, 64'h3f800000);
        check("rsv fault", o_reserved_fault, 1'b1);
        i_norm_mode = 1'b0;
        run(OP_CMP_REAL, 64'h00000001, 64'h3f800000);
        check("rsv clear", o_reserved_fault, 1'b0);
        check("denorm lt", o_condition_code_field, 3'h4);
    endtask

    task automatic t_unknown();
        run(12'h5ae, 64'h1, 64'h2);
        check("unknown", o_unknown_op, 1'b1);
        check("unk no wb", o_result_we, 1'b0);
        check("unk no cc", o_cc_we, 1'b0);
    endtask

    initial begin
        i_clk = 1'b0;
        i_rst_n = 1'b0;
        i_valid = 1'b0;
        i_opcode = 12'h0;
        i_first_reg = 5'h0;
        i_second_reg = 5'h0;
        i_first_operand = 64'h0;
        i_second_operand = 64'h0;
        i_norm_mode = 1'b0;
        i_invalid_mask = 1'b0;
        fails = 0;
        n_compared = 0;
        cycles = 0;
        repeat (6) @(posedge i_clk);
        #1;
        check("reset done", o_done, 1'b0);
        check("reset cc", o_condition_code_field, 3'h0);
        i_rst_n = 1'b1;
        t_clear_bit();
        t_compare();
        t_dec_inc();
        t_real();
        t_reserved();
        t_unknown();
        print_verdict();
    end
endmodule // cbc_unit_tb
